// ==== bsr_pkg.sv ====
// bsr_pkg: offsets, lane positions and answer values of the
// board status register bank.
// assumes byte offsets within the external register window.
package bsr_pkg;

    // register offsets within the window
    localparam logic [15:0] OFS_SWITCH = 16'h80e0;
    localparam logic [15:0] OFS_SLOT = 16'h80e8;
    localparam logic [15:0] OFS_FEATURE = 16'h80f0;
    localparam logic [15:0] OFS_CAUSE = 16'h80f8;

    // the 8-bit register sits in the top byte of the 64-bit path
    localparam int DATA_W = 64;
    localparam int LANE_MSB = 63;
    localparam int LANE_LSB = 56;

    // byte bit index of each field; lane n is byte bit 7-n
    localparam int SLOT_PAR_BIT = 5;
    localparam int EXP_SLOT_BIT = 7;
    localparam int MOD1_BIT = 4;
    localparam int MOD2_BIT = 3;
    localparam int MEZZ1_BIT = 1;
    localparam int MEZZ2_BIT = 0;
    localparam int CAUSE_PWR_BIT = 0;
    localparam int CAUSE_BTN_BIT = 1;
    localparam int CAUSE_WDT_BIT = 2;
    localparam int CAUSE_BPL_BIT = 3;
    localparam int CAUSE_CMD_BIT = 4;
    localparam int CAUSE_SOFT_BIT = 5;

    // value of the reset cause record after arst_n
    localparam logic [7:0] CAUSE_RST = 8'h00;
    // answer for an unmapped offset and for unused lanes
    localparam logic [63:0] RDATA_IDLE = 64'h0;

    typedef enum logic [2:0] {
        BSR_SEL_NONE,
        BSR_SEL_SWITCH,
        BSR_SEL_SLOT,
        BSR_SEL_FEATURE,
        BSR_SEL_CAUSE
    } bsr_sel_t;

endpackage

// ==== bsr_status_bank.sv ====
// bsr_status_bank: read-only board status registers on the
// 8-bit external register bus, carried on the top data byte.
// assumes strobes and pins synchronous to clk_sys; the board reset
// logic pulses one cause input once per board reset.
`timescale 1ns/100ps

module bsr_status_bank
    import bsr_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    input wire logic clk_sys, // 20 MHz bus clock
    input wire logic arst_n, // async reset, low active
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic [ADDR_W-1:0] reg_addr, // byte offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data, ignored
    output logic [DATA_W-1:0] reg_rdata, // read answer
    output logic reg_ack, // answer strobe
    input wire logic [7:0] cfg_switch_closed, // 1 = position on
    input wire logic slot_parity_n, // backplane parity pin
    input wire logic [4:0] slot_addr_n, // backplane address pins
    input wire logic module1_absent, // no module in position 1
    input wire logic module2_absent, // no module in position 2
    input wire logic mezz1_absent, // no mezzanine 1
    input wire logic mezz2_absent, // no mezzanine 2
    input wire logic exp_slot_absent, // expansion slot empty
    input wire logic cause_power_up, // power-on or undervoltage
    input wire logic cause_button, // front panel button
    input wire logic cause_watchdog, // watchdog level 2 expiry
    input wire logic cause_soft_hard // fast reset bit
);

    generate
        if (ADDR_W < 16)
        begin : g_chk
            $error("bsr_status_bank: ADDR_W must be at least 16");
        end
    endgenerate

    // address decode

    bsr_sel_t sel;
    logic [15:0] ofs;

    assign ofs = reg_addr[15:0];

    always_comb
    begin
        if (ofs == OFS_SWITCH)
            sel = BSR_SEL_SWITCH;
        else if (ofs == OFS_SLOT)
            sel = BSR_SEL_SLOT;
        else if (ofs == OFS_FEATURE)
            sel = BSR_SEL_FEATURE;
        else if (ofs == OFS_CAUSE)
            sel = BSR_SEL_CAUSE;
        else
            sel = BSR_SEL_NONE;
    end

    // live status bytes, lane 0 in byte bit 7

    logic [7:0] switch_byte;
    logic [7:0] slot_byte;
    logic [7:0] feature_byte;

    always_comb
    begin
        // lane k carries switch bit 7-k inverted, so the byte is in order
        switch_byte = ~cfg_switch_closed;
        slot_byte = 8'h00;
        slot_byte[SLOT_PAR_BIT] = slot_parity_n;
        slot_byte[4:0] = slot_addr_n;
        // both feature registers share one offset; lane 0 is free
        // in the first, so the slot bit fills it
        feature_byte = 8'h00;
        feature_byte[EXP_SLOT_BIT] = exp_slot_absent;
        feature_byte[MOD1_BIT] = module1_absent;
        feature_byte[MOD2_BIT] = module2_absent;
        feature_byte[MEZZ1_BIT] = mezz1_absent;
        feature_byte[MEZZ2_BIT] = mezz2_absent;
    end

    // reset cause record

    logic [7:0] cause_rec;
    logic [7:0] next_cause_rec;
    logic [7:0] cause_evt;

    always_comb
    begin
        cause_evt = 8'h00;
        cause_evt[CAUSE_PWR_BIT] = cause_power_up;
        cause_evt[CAUSE_BTN_BIT] = cause_button;
        cause_evt[CAUSE_WDT_BIT] = cause_watchdog;
        cause_evt[CAUSE_SOFT_BIT] = cause_soft_hard;
        // backplane and remote command causes do not exist here
        cause_evt[CAUSE_BPL_BIT] = 1'b0;
        cause_evt[CAUSE_CMD_BIT] = 1'b0;
        // a new reset replaces the old record rather than adding
        // to it, so only the most recent cause stays visible
        if (|cause_evt)
            next_cause_rec = cause_evt;
        else
            next_cause_rec = cause_rec;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cause_rec <= CAUSE_RST;
        else
            cause_rec <= next_cause_rec;
    end

    // bus answer

    logic [DATA_W-1:0] next_reg_rdata;
    logic next_reg_ack;
    logic [7:0] rd_byte;

    always_comb
    begin
        case (sel)
            BSR_SEL_SWITCH: rd_byte = switch_byte;
            BSR_SEL_SLOT: rd_byte = slot_byte;
            BSR_SEL_FEATURE: rd_byte = feature_byte;
            BSR_SEL_CAUSE: rd_byte = cause_rec;
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb
    begin
        next_reg_ack = reg_rd | reg_wr;
        next_reg_rdata = reg_rdata;
        // reads load the top byte; writes leave the answer alone
        if (reg_rd)
        begin
            next_reg_rdata = RDATA_IDLE;
            next_reg_rdata[LANE_MSB:LANE_LSB] = rd_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= RDATA_IDLE;
            reg_ack <= 1'b0;
        end
        else
        begin
            reg_rdata <= next_reg_rdata;
            reg_ack <= next_reg_ack;
        end
    end

    // checks; read answers are registered, so they are judged one edge later

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!arst_n);

    property p_ack_one;
        (reg_rd || reg_wr) |=> reg_ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("access not answered next cycle");

    property p_low_zero;
        reg_ack && $past(reg_rd) |-> reg_rdata[55:0] == 56'h0;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("low lanes not zero on read");

    property p_switch;
        reg_rd && reg_addr[15:0] == OFS_SWITCH
            |=> reg_rdata[63:56] == ~$past(cfg_switch_closed);
    endproperty
    a_switch: assert property (p_switch)
        else $error("switch byte wrong");

    property p_slot;
        reg_rd && reg_addr[15:0] == OFS_SLOT
            |=> reg_rdata[63:56]
                == {2'b00, $past(slot_parity_n), $past(slot_addr_n)};
    endproperty
    a_slot: assert property (p_slot)
        else $error("slot address byte wrong");

    property p_feature;
        reg_rd && reg_addr[15:0] == OFS_FEATURE
            |=> reg_rdata[63:56] == {$past(exp_slot_absent), 2'b00,
                $past(module1_absent), $past(module2_absent), 1'b0,
                $past(mezz1_absent), $past(mezz2_absent)};
    endproperty
    a_feature: assert property (p_feature)
        else $error("feature byte wrong");

    // simultaneous causes are all kept, so only a lone pulse is judged here
    property p_cause_load;
        cause_power_up && !(cause_button || cause_watchdog || cause_soft_hard)
            |=> cause_rec[CAUSE_PWR_BIT] && $onehot(cause_rec);
    endproperty
    a_cause_load: assert property (p_cause_load)
        else $error("power-on cause not recorded alone");

    property p_cause_hold;
        !(cause_power_up || cause_button || cause_watchdog
            || cause_soft_hard) |=> $stable(cause_rec);
    endproperty
    a_cause_hold: assert property (p_cause_hold)
        else $error("cause record changed without event");

    property p_cause_unused;
        reg_rd && reg_addr[15:0] == OFS_CAUSE
            |=> reg_rdata[60:59] == 2'b00 && reg_rdata[63:62] == 2'b00;
    endproperty
    a_cause_unused: assert property (p_cause_unused)
        else $error("unused cause lanes set");

    property p_write_inert;
        reg_wr && !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_write_inert: assert property (p_write_inert)
        else $error("write changed read answer");

    property p_ack_idle;
        !(reg_rd || reg_wr) |=> !reg_ack;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("answer without access");

    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read answer changed without read");

    property p_cause_read;
        reg_rd && reg_addr[15:0] == OFS_CAUSE
            |=> reg_rdata[63:56] == $past(cause_rec);
    endproperty
    a_cause_read: assert property (p_cause_read)
        else $error("cause record not returned");

    property p_cause_button;
        cause_button && !(cause_power_up || cause_watchdog || cause_soft_hard)
            |=> cause_rec[CAUSE_BTN_BIT] && $onehot(cause_rec);
    endproperty
    a_cause_button: assert property (p_cause_button)
        else $error("button cause not recorded alone");

    property p_cause_watchdog;
        cause_watchdog && !(cause_power_up || cause_button || cause_soft_hard)
            |=> cause_rec[CAUSE_WDT_BIT] && $onehot(cause_rec);
    endproperty
    a_cause_watchdog: assert property (p_cause_watchdog)
        else $error("watchdog cause not recorded alone");

    property p_cause_soft;
        cause_soft_hard && !(cause_power_up || cause_button || cause_watchdog)
            |=> cause_rec[CAUSE_SOFT_BIT] && $onehot(cause_rec);
    endproperty
    a_cause_soft: assert property (p_cause_soft)
        else $error("soft hard reset cause not recorded alone");

    // an offset outside the bank must not leak a stale byte
    property p_unmapped;
        reg_rd && reg_addr[15:0] != OFS_SWITCH && reg_addr[15:0] != OFS_SLOT
            && reg_addr[15:0] != OFS_FEATURE && reg_addr[15:0] != OFS_CAUSE
            |=> reg_rdata == RDATA_IDLE;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped offset read not zero");

    property p_exp_slot;
        reg_rd && reg_addr[15:0] == OFS_FEATURE
            |=> reg_rdata[LANE_MSB] == $past(exp_slot_absent);
    endproperty
    a_exp_slot: assert property (p_exp_slot)
        else $error("expansion slot bit wrong");

endmodule // bsr_status_bank

// ==== bsr_host_model.sv ====
// bsr_host_model: bus master standing in for the host bridge side.
// assumes a one-cycle strobe and a registered ack one cycle later.
`timescale 1ns/100ps
module bsr_host_model (
    input wire logic clk_sys, // bus clock
    output logic reg_rd, // read strobe
    output logic reg_wr, // write strobe
    output logic [15:0] reg_addr, // byte offset
    output logic [63:0] reg_wdata, // write data
    input wire logic [63:0] reg_rdata, // read answer
    input wire logic reg_ack // answer strobe
);
    initial
    begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 64'h0;
    end
    // one access; strobes move on the falling edge only
    task automatic access(input logic wr, input logic [15:0] a, input logic [63:0] wd,
                          output logic [63:0] rd, output logic ack);
        @(negedge clk_sys);
        reg_rd <= ~wr;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= wd;
        @(negedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        // released lines show the inverse so a stale copy cannot pass
        reg_addr <= ~a;
        reg_wdata <= ~wd;
        ack = reg_ack;
        rd = reg_rdata;
    endtask
endmodule // bsr_host_model

// ==== bsr_tb.sv ====
// testbench: exercises the status bank through the host model.
// assumes a 20 MHz clk_sys and the cause record clearing under arst_n.
`timescale 1ns/100ps
module testbench;
    import bsr_pkg::*;
    logic clk_sys, arst_n, reg_rd, reg_wr, reg_ack;
    logic [15:0] reg_addr;
    logic [63:0] reg_wdata, reg_rdata;
    logic [7:0] cfg_switch_closed;
    logic slot_parity_n, module1_absent, module2_absent, mezz1_absent, mezz2_absent;
    logic [4:0] slot_addr_n;
    logic exp_slot_absent, cause_power_up, cause_button, cause_watchdog, cause_soft_hard;
    int fails, compares;

    bsr_status_bank #(.ADDR_W(16)) u_dut (.clk_sys, .arst_n, .reg_rd, .reg_wr,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .cfg_switch_closed,
        .slot_parity_n, .slot_addr_n, .module1_absent, .module2_absent,
        .mezz1_absent, .mezz2_absent, .exp_slot_absent, .cause_power_up,
        .cause_button, .cause_watchdog, .cause_soft_hard);
    bsr_host_model u_host (.clk_sys, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_ack);

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [15:0] a, output logic [63:0] d);
        logic k;
        u_host.access(1'b0, a, 64'h0, d, k);
        check({63'h0, k}, 64'h1);
    endtask

    task automatic t_switch();
        logic [63:0] d;
        for (int i = 0; i < 8; i++)
        begin
            cfg_switch_closed = 8'h01 << i;
            rd(OFS_SWITCH, d);
            check(d, {~(8'h01 << i), 56'h0});
        end
    endtask

    task automatic t_slot();
        logic [63:0] d;
        logic [5:0] v;
        for (int i = 0; i < 6; i++)
        begin
            v = 6'h01 << i;
            {slot_parity_n, slot_addr_n} = v;
            rd(OFS_SLOT, d);
            check(d, {2'b00, v, 56'h0});
        end
    endtask

    task automatic t_feature();
        logic [63:0] d;
        logic [4:0] v;
        for (int i = 0; i < 5; i++)
        begin
            v = 5'h01 << i;
            {exp_slot_absent, module1_absent, module2_absent, mezz1_absent, mezz2_absent} = v;
            rd(OFS_FEATURE, d);
            check(d, {v[4], 2'b00, v[3:2], 1'b0, v[1:0], 56'h0});
        end
    endtask

    task automatic t_cause();
        logic [63:0] d;
        logic [3:0] v;
        rd(OFS_CAUSE, d);
        check(d, {CAUSE_RST, 56'h0});
        for (int i = 0; i < 5; i++)
        begin
            // the last pass fires every cause at once
            v = (i == 4) ? 4'hf : 4'h1 << i;
            {cause_soft_hard, cause_watchdog, cause_button, cause_power_up} = v;
            @(negedge clk_sys);
            {cause_soft_hard, cause_watchdog, cause_button, cause_power_up} = 4'h0;
            rd(OFS_CAUSE, d);
            check(d, {2'b00, v[3], 2'b00, v[2:0], 56'h0});
        end
    endtask

    task automatic t_write();
        logic [63:0] d, prev;
        logic k;
        for (int i = 0; i < 4; i++)
        begin
            rd(OFS_CAUSE, prev);
            u_host.access(1'b1, OFS_SWITCH + 16'(8 * i), 64'hffffffffffffffff, d, k);
            check({63'h0, k}, 64'h1);
            check(d, prev);
            rd(OFS_CAUSE, d);
            check(d, prev);
        end
        rd(16'h80c8, d);
        check(d, RDATA_IDLE);
    endtask

    // the memory/clock path lies outside this bank: the three steps are
    // answered and leave the status registers untouched
    task automatic t_nv_access();
        logic [63:0] d, prev;
        logic k;
        rd(OFS_CAUSE, prev);
        u_host.access(1'b1, 16'h80c8, {8'h5a, 56'h0}, d, k);
        check({63'h0, k}, 64'h1);
        u_host.access(1'b1, 16'h80d0, {8'h01, 56'h0}, d, k);
        check({63'h0, k}, 64'h1);
        rd(16'h80d8, d);
        check(d, RDATA_IDLE);
        rd(OFS_CAUSE, d);
        check(d, prev);
    endtask

    // a mid-run reset must drop the answer and forget the last cause
    task automatic t_reset();
        logic [63:0] d;
        cause_button = 1'b1;
        @(negedge clk_sys);
        cause_button = 1'b0;
        rd(OFS_CAUSE, d);
        check(d, {8'(1 << CAUSE_BTN_BIT), 56'h0});
        arst_n = 1'b0;
        @(negedge clk_sys);
        check({63'h0, reg_ack}, 64'h0);
        check(reg_rdata, RDATA_IDLE);
        arst_n = 1'b1;
        rd(OFS_CAUSE, d);
        check(d, {CAUSE_RST, 56'h0});
    endtask

    task automatic report_and_stop();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        fails = 0;
        compares = 0;
        arst_n = 1'b0;
        cfg_switch_closed = 8'h00;
        {slot_parity_n, slot_addr_n} = 6'h00;
        {exp_slot_absent, module1_absent, module2_absent, mezz1_absent, mezz2_absent} = 5'h00;
        {cause_soft_hard, cause_watchdog, cause_button, cause_power_up} = 4'h0;
        repeat (6) @(negedge clk_sys);
        arst_n = 1'b1;
        t_switch();
        t_slot();
        t_feature();
        t_cause();
        t_write();
        t_nv_access();
        t_reset();
        report_and_stop();
    end

    // whole run is about a hundred cycles; this leaves ample margin
    initial
    begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule // testbench
